// File: cbt_consts.vh
// register map, field positions, reset values and timing constants
`ifndef CBT_CONSTS_VH
`define CBT_CONSTS_VH
`define CBT_ADDR_W        3
`define CBT_OFF_FLAGS     3'h0
`define CBT_OFF_ENABLES   3'h1
`define CBT_OFF_ERRCNT    3'h2
`define CBT_OFF_CFG_A     3'h3
`define CBT_OFF_CFG_B     3'h4
`define CBT_OFF_EVENTS    3'h5
`define CBT_FLAG_TXB      0
`define CBT_FLAG_RXB      1
`define CBT_FLAG_RXOVF    2
`define CBT_FLAG_FIFO     3
`define CBT_FLAG_ERR      5
`define CBT_FLAG_WAKE     6
`define CBT_FLAG_INVMSG   7
`define CBT_EVT_MASK      8'hEF
`define CBT_ENA_RST       8'h00
`define CBT_CFG_A_RST     8'h00
`define CBT_CFG_B_RST     12'h000
`define CBT_CFG_B_MASK    16'h47FF
`define CBT_IPT_TQ        4'h2
`define CBT_WAKE_FILT_N   4'h3
`endif

// File: cbt_sampler.v
// majority-of-three bus line sampler with single-sample bypass
`timescale 1ns/100ps
`default_nettype none
module cbt_sampler (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       shift,
  input  wire       line,
  input  wire       triple,
  output reg        sample
);
  reg [2:0] hist_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hist_reg <= 3'h7;
      sample   <= 1'b1;
    end else if (shift) begin
      hist_reg <= {hist_reg[1:0], line};
      if (triple) begin
        sample <= (hist_reg[1] & hist_reg[0]) | (hist_reg[1] & line) | (hist_reg[0] & line);
      end else begin
        sample <= line;
      end
    end
  end
endmodule
`default_nettype wire

// File: cbt_regs.v
// bit timing, interrupt flags, enables and error counter registers
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cbt_consts.vh"
module cbt_regs (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [2:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata,
  input  wire [7:0]  tx_error_counter,
  input  wire [7:0]  rx_error_counter,
  input  wire [5:0]  err_state,
  input  wire        tx_buffer_evt,
  input  wire        rx_buffer_evt,
  input  wire        rx_overflow_evt,
  input  wire        fifo_almost_full_evt,
  input  wire        invalid_msg_evt,
  input  wire        can_rx,
  input  wire        resync_edge_early,
  input  wire        resync_edge_late,
  output wire        irq,
  output reg         sample_point,
  output reg         bit_start,
  output wire        bus_sample,
  output reg  [1:0]  seg_state
);
  localparam S_SYNC = 2'h0;
  localparam S_PROP = 2'h1;
  localparam S_PH1  = 2'h2;
  localparam S_PH2  = 2'h3;

  // pin input, error state and error counters pass two flops
  reg [1:0]  rx_sync_reg;
  reg [5:0]  err_s1_reg;
  reg [5:0]  err_s2_reg;
  reg [15:0] cnt_s1_reg;
  reg [15:0] cnt_s2_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_sync_reg <= 2'h3;
      err_s1_reg  <= 6'h00;
      err_s2_reg  <= 6'h00;
      cnt_s1_reg  <= 16'h0000;
      cnt_s2_reg  <= 16'h0000;
    end else begin
      rx_sync_reg <= {rx_sync_reg[0], can_rx};
      err_s1_reg  <= err_state;
      err_s2_reg  <= err_s1_reg;
      cnt_s1_reg  <= {tx_error_counter, rx_error_counter};
      cnt_s2_reg  <= cnt_s1_reg;
    end
  end
  wire rx_line = rx_sync_reg[1];

  // configuration registers
  reg [7:0]  enables_reg;
  reg [7:0]  cfg_a_reg;
  reg [11:0] cfg_b_reg;
  wire [1:0] resync_jump_width      = cfg_a_reg[7:6];
  wire [5:0] quantum_prescaler      = cfg_a_reg[5:0];
  wire       wakeup_line_filter_sel = cfg_b_reg[11];
  wire [2:0] phase_two_length       = cfg_b_reg[10:8];
  wire       phase_two_select       = cfg_b_reg[7];
  wire       triple_sample_sel      = cfg_b_reg[6];
  wire [2:0] phase_one_length       = cfg_b_reg[5:3];
  wire [2:0] propagation_length     = cfg_b_reg[2:0];

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enables_reg <= `CBT_ENA_RST;
      cfg_a_reg   <= `CBT_CFG_A_RST;
      cfg_b_reg   <= `CBT_CFG_B_RST;
    end else if (wr) begin
      case (addr)
        `CBT_OFF_ENABLES: enables_reg <= wdata[7:0] & `CBT_EVT_MASK;
        `CBT_OFF_CFG_A:   cfg_a_reg <= wdata[7:0];
        `CBT_OFF_CFG_B:   cfg_b_reg <= {wdata[14], wdata[10:0]};
        default: begin
        end
      endcase
    end
  end

  // time quantum: prescaler counts 2*(p+1) clocks
  reg [6:0] tq_cnt_reg;
  wire [6:0] tq_last = {quantum_prescaler, 1'b1};
  wire       tq_tick = (tq_cnt_reg == tq_last);
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tq_cnt_reg <= 7'h00;
    end else if (tq_tick) begin
      tq_cnt_reg <= 7'h00;
    end else begin
      tq_cnt_reg <= tq_cnt_reg + 7'h01;
    end
  end

  // segment lengths in quanta
  wire [3:0] prop_len = {1'b0, propagation_length} + 4'h1;
  wire [3:0] ph1_len  = {1'b0, phase_one_length} + 4'h1;
  wire [3:0] ph2_prog = {1'b0, phase_two_length} + 4'h1;
  wire [3:0] ph2_auto = (ph1_len > `CBT_IPT_TQ) ? ph1_len : `CBT_IPT_TQ;
  wire [3:0] ph2_len  = phase_two_select ? ph2_prog : ph2_auto;
  wire [2:0] sjw_len  = {1'b0, resync_jump_width} + 3'h1;

  // resynchronisation: stretch phase one or shorten phase two by at most sjw
  reg        early_s1_reg;
  reg        early_s2_reg;
  reg        late_s1_reg;
  reg        late_s2_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      early_s1_reg <= 1'b0;
      early_s2_reg <= 1'b0;
      late_s1_reg  <= 1'b0;
      late_s2_reg  <= 1'b0;
    end else begin
      early_s1_reg <= resync_edge_early;
      early_s2_reg <= early_s1_reg;
      late_s1_reg  <= resync_edge_late;
      late_s2_reg  <= late_s1_reg;
    end
  end

  reg [3:0] seg_cnt_reg;
  reg [3:0] ph1_ext_reg;
  reg [3:0] ph2_cut_reg;
  reg [3:0] seg_end;
  always @* begin
    case (seg_state)
      S_SYNC:  seg_end = 4'h1;
      S_PROP:  seg_end = prop_len;
      S_PH1:   seg_end = ph1_len + ph1_ext_reg;
      S_PH2:   seg_end = (ph2_len > ph2_cut_reg) ? ph2_len - ph2_cut_reg : 4'h1;
      default: seg_end = 4'h1;
    endcase
  end
  wire seg_done = tq_tick && (seg_cnt_reg + 4'h1 >= seg_end);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seg_state    <= S_SYNC;
      seg_cnt_reg  <= 4'h0;
      ph1_ext_reg  <= 4'h0;
      ph2_cut_reg  <= 4'h0;
      sample_point <= 1'b0;
      bit_start    <= 1'b0;
    end else begin
      sample_point <= 1'b0;
      bit_start    <= 1'b0;
      if (late_s2_reg && seg_state == S_PH1) begin
        ph1_ext_reg <= {1'b0, sjw_len};
      end
      if (early_s2_reg && seg_state == S_PH2) begin
        ph2_cut_reg <= {1'b0, sjw_len};
      end
      if (tq_tick) begin
        if (seg_done) begin
          seg_cnt_reg <= 4'h0;
          case (seg_state)
            S_SYNC: seg_state <= S_PROP;
            S_PROP: seg_state <= S_PH1;
            S_PH1: begin
              seg_state    <= S_PH2;
              sample_point <= 1'b1;
              ph1_ext_reg  <= 4'h0;
            end
            S_PH2: begin
              seg_state   <= S_SYNC;
              bit_start   <= 1'b1;
              ph2_cut_reg <= 4'h0;
            end
            default: seg_state <= S_SYNC;
          endcase
        end else begin
          seg_cnt_reg <= seg_cnt_reg + 4'h1;
        end
      end
    end
  end

  // sampled line: three samples on the last three phase-one quanta, of earlier bits if phase one is shorter, end at sample point
  wire shift_en = tq_tick && (seg_state == S_PH1);
  cbt_sampler u_sampler (
    .clk    (clk),
    .rst_b  (rst_b),
    .shift  (shift_en),
    .line   (rx_line),
    .triple (triple_sample_sel),
    .sample (bus_sample)
  );

  // wake-up: dominant level held for several quanta when filtered
  reg [3:0] wake_cnt_reg;
  reg       rx_prev_reg;
  wire      wake_filt = (wake_cnt_reg == `CBT_WAKE_FILT_N);
  wire      wake_raw  = rx_prev_reg & ~rx_line;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_cnt_reg <= 4'h0;
      rx_prev_reg  <= 1'b1;
    end else begin
      rx_prev_reg <= rx_line;
      if (rx_line) begin
        wake_cnt_reg <= 4'h0;
      end else if (tq_tick && wake_cnt_reg != 4'hF) begin
        wake_cnt_reg <= wake_cnt_reg + 4'h1;
      end
    end
  end
  reg wake_filt_d_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_filt_d_reg <= 1'b0;
    end else begin
      wake_filt_d_reg <= wake_filt;
    end
  end
  wire wake_evt = wakeup_line_filter_sel ? (wake_filt & ~wake_filt_d_reg) : wake_raw;

  // error summary rises on any new error-state source
  reg [5:0] err_prev_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_prev_reg <= 6'h00;
    end else begin
      err_prev_reg <= err_s2_reg;
    end
  end
  wire err_evt = |(err_s2_reg & ~err_prev_reg);

  // sticky flags, set beats write-one-to-clear
  wire [7:0] evt_vec = {invalid_msg_evt, wake_evt, err_evt, 1'b0, fifo_almost_full_evt,
                        rx_overflow_evt, rx_buffer_evt, tx_buffer_evt};
  reg  [7:0] flags_reg;
  wire [7:0] flags_clr = (wr && addr == `CBT_OFF_FLAGS) ? wdata[7:0] : 8'h00;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_reg <= 8'h00;
    end else begin
      flags_reg <= ((flags_reg & ~flags_clr) | evt_vec) & `CBT_EVT_MASK;
    end
  end

  assign irq = |(flags_reg & enables_reg);

  // read port, data one cycle after strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `CBT_OFF_FLAGS:   rdata <= {2'h0, err_s2_reg, flags_reg};
        `CBT_OFF_ENABLES: rdata <= {8'h00, enables_reg};
        `CBT_OFF_ERRCNT:  rdata <= cnt_s2_reg;
        `CBT_OFF_CFG_A:   rdata <= {8'h00, cfg_a_reg};
        `CBT_OFF_CFG_B:   rdata <= {1'b0, cfg_b_reg[11], 3'h0, cfg_b_reg[10:0]};
        default:          rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// File: cbt_regs_chk.sv
// assertion checker for the bit timing and interrupt register block
`timescale 1ns/100ps
`default_nettype none
`include "cbt_consts.vh"
module cbt_regs_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [2:0]  addr,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic [7:0]  tx_error_counter,
  input wire logic [7:0]  rx_error_counter,
  input wire logic        irq,
  input wire logic        sample_point,
  input wire logic        bit_start
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // shortest bit is four quanta of two clocks
  sequence quiet_bit;
    !bit_start [*7];
  endsequence
  a_read_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_enable_rsvd: assert property ($past(rd) && $past(addr) == 3'h1 |-> rdata[15:8] == 8'h00 && !rdata[4])
    else $error("reserved enable bits not zero");
  a_cfga_rsvd: assert property ($past(rd) && $past(addr) == 3'h3 |-> rdata[15:8] == 8'h00)
    else $error("reserved config a bits not zero");
  a_cfgb_rsvd: assert property ($past(rd) && $past(addr) == 3'h4 |-> (rdata & ~`CBT_CFG_B_MASK) == 16'h0000)
    else $error("reserved config b bits not zero");
  // counters pass two sync flops, so only judge a stable input
  a_count_read: assert property (rd && addr == 3'h2 && $past(rst_b, 3) && $stable(tx_error_counter)
    && $stable(rx_error_counter) && $past(tx_error_counter, 2) == tx_error_counter
    && $past(rx_error_counter, 2) == rx_error_counter
    |=> rdata == {$past(tx_error_counter), $past(rx_error_counter)})
    else $error("error counter read mismatch");
  a_irq_drop: assert property ($fell(irq) |-> $past(wr))
    else $error("interrupt dropped without a write");
  a_bit_min: assert property (bit_start |=> quiet_bit)
    else $error("bit shorter than four quanta");
  a_point_apart: assert property (sample_point |-> !bit_start)
    else $error("sample point coincides with bit start");
endmodule
`default_nettype wire

// File: cbt_bus_model.sv
// far side stand-in: bus line behind a transceiver, recessive high when idle
`timescale 1ns/100ps
`default_nettype none
module cbt_bus_model (
  input  wire logic clk,
  output var  logic can_rx
);
  initial can_rx = 1'b1;
  // dominant for n clocks, then back to recessive
  task automatic dominant(input int n);
    @(posedge clk);
    can_rx <= 1'b0;
    repeat (n) @(posedge clk);
    can_rx <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: cbt_regs_test.sv
// self-checking bench for the bit timing and interrupt register block
`timescale 1ns/100ps
`default_nettype none
`include "cbt_consts.vh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module cbt_regs_test;
  logic        clk, rst_b, wr, rd, irq, sample_point, bit_start, bus_sample, can_rx;
  logic [2:0]  addr;
  logic [15:0] wdata, rdata;
  logic [7:0]  tx_cnt, rx_cnt;
  logic [5:0]  err_state;
  logic [4:0]  evt;
  logic [1:0]  seg_state, resync;
  logic [15:0] cfg [2] = '{16'h038A, 16'h000A};
  int          ph2 [2] = '{16, 8};
  int          bad_count, compares;
  cbt_regs dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tx_error_counter(tx_cnt), .rx_error_counter(rx_cnt),
    .err_state(err_state), .tx_buffer_evt(evt[0]), .rx_buffer_evt(evt[1]),
    .rx_overflow_evt(evt[2]), .fifo_almost_full_evt(evt[3]), .invalid_msg_evt(evt[4]),
    .can_rx(can_rx), .resync_edge_early(resync[0]), .resync_edge_late(resync[1]),
    .irq(irq), .sample_point(sample_point), .bit_start(bit_start),
    .bus_sample(bus_sample), .seg_state(seg_state));
  cbt_bus_model bus (.clk(clk), .can_rx(can_rx));
  always #2 clk = ~clk;
  task automatic stop_test;
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  task automatic pulse(input logic [4:0] e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= 5'h00;
    #1;
  endtask
  // counts clocks up to the next pulse; zero means measure without judging
  task automatic upto(input bit to_start, input int e);
    int c;
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while ((to_start ? bit_start : sample_point) !== 1'b1 && c < 300);
    if (c >= 300) begin
      bad_count++;
      stop_test();
    end
    if (e != 0) `CHK("span", e, c)
  endtask
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {wr, rd, addr, wdata, tx_cnt, rx_cnt, err_state, evt, resync} = '0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 5; a++) rd_chk(a[2:0], 16'h0000);
    wr_reg(`CBT_OFF_ENABLES, 16'hFFFF);
    rd_chk(`CBT_OFF_ENABLES, 16'h00EF);
    `CHK("irq", 1'b0, irq)
    pulse(5'h1F);
    @(posedge clk);
    err_state <= 6'h21;
    repeat (4) @(posedge clk);
    rd_chk(`CBT_OFF_FLAGS, 16'h21AF);
    `CHK("irq", 1'b1, irq)
    wr_reg(`CBT_OFF_FLAGS, 16'h00FF);
    rd_chk(`CBT_OFF_FLAGS, 16'h2100);
    `CHK("irq", 1'b0, irq)
    wr_reg(`CBT_OFF_ENABLES, 16'h0000);
    pulse(5'h01);
    `CHK("irq", 1'b0, irq)
    wr_reg(`CBT_OFF_ENABLES, 16'h0001);
    `CHK("irq", 1'b1, irq)
    wr_reg(`CBT_OFF_FLAGS, 16'h0001);
    `CHK("irq", 1'b0, irq)
    wr_reg(`CBT_OFF_CFG_B, 16'h4000);
    bus.dominant(2);
    repeat (10) @(posedge clk);
    rd_chk(`CBT_OFF_FLAGS, 16'h2100);
    bus.dominant(40);
    repeat (10) @(posedge clk);
    rd_chk(`CBT_OFF_FLAGS, 16'h2140);
    wr_reg(`CBT_OFF_FLAGS, 16'h0040);
    wr_reg(`CBT_OFF_CFG_B, 16'h0000);
    bus.dominant(2);
    repeat (10) @(posedge clk);
    rd_chk(`CBT_OFF_FLAGS, 16'h2140);
    @(posedge clk);
    tx_cnt <= 8'hA5;
    rx_cnt <= 8'h3C;
    repeat (3) @(posedge clk);
    wr_reg(`CBT_OFF_ERRCNT, 16'h0000);
    rd_chk(`CBT_OFF_ERRCNT, 16'hA53C);
    wr_reg(3'h7, 16'hFFFF);
    rd_chk(3'h7, 16'h0000);
    wr_reg(`CBT_OFF_CFG_A, 16'hFFFF);
    rd_chk(`CBT_OFF_CFG_A, 16'h00FF);
    wr_reg(`CBT_OFF_CFG_B, 16'hFFFF);
    rd_chk(`CBT_OFF_CFG_B, 16'h47FF);
    wr_reg(`CBT_OFF_CFG_A, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      wr_reg(`CBT_OFF_CFG_B, cfg[i]);
      upto(1'b1, 0);
      upto(1'b0, 24);
      upto(1'b1, ph2[i]);
    end
    // late edge stretches phase one, early edge cuts phase two, one quantum each
    wr_reg(`CBT_OFF_CFG_B, cfg[0]);
    upto(1'b1, 0);
    @(posedge clk);
    resync <= 2'h2;
    upto(1'b0, 27);
    @(posedge clk);
    resync <= 2'h1;
    upto(1'b1, 11);
    @(posedge clk);
    resync <= 2'h0;
    `CHK("bus_sample", 1'b1, bus_sample)
    stop_test();
  end
endmodule
bind cbt_regs cbt_regs_chk chk (.clk(clk), .rst_b(rst_b), .addr(addr), .wr(wr), .rd(rd),
  .rdata(rdata), .tx_error_counter(tx_error_counter), .rx_error_counter(rx_error_counter),
  .irq(irq), .sample_point(sample_point), .bit_start(bit_start));
`default_nettype wire
